/* design/fol_pkg.sv */
// Package of constants and carrier types for the fault onset and limit timer.
package fol_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  localparam int CLK_HZ        = 40_000_000;
  localparam int TICK_MS       = 1;
  localparam int MS_CYCLES     = CLK_HZ / 1000 * TICK_MS;

  // ---------------------------------------------------------------------
  // Setting ranges (milliseconds and tenths of a degree)
  // ---------------------------------------------------------------------
  localparam logic [15:0] LIMIT_MIN_MS   = 16'h0001;
  localparam logic [15:0] LIMIT_MAX_MS   = 16'hfde8;
  localparam logic [15:0] LEAD_MIN_MS    = 16'h000a;
  localparam logic [15:0] LEAD_MAX_MS    = 16'h1770;
  localparam logic [11:0] ANGLE_MAX      = 12'he0f;
  localparam logic [11:0] PHASE_LAST     = 12'he0f;

  // ---------------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_LIMIT     = 8'h04;
  localparam logic [7:0]  ADDR_LEAD      = 8'h08;
  localparam logic [7:0]  ADDR_ANGLE     = 8'h0c;
  localparam logic [7:0]  ADDR_STEP      = 8'h10;
  localparam logic [7:0]  ADDR_STATUS    = 8'h14;
  localparam logic [15:0] RST_LIMIT      = 16'h03e8;
  localparam logic [15:0] RST_LEAD       = 16'h000a;
  localparam logic [11:0] RST_ANGLE      = 12'h000;
  localparam logic [23:0] RST_STEP       = 24'h0126e9;

  // Field positions in the control register.
  localparam int CTRL_QC_BIT    = 0;
  localparam int CTRL_LIMIT_BIT = 1;
  localparam int CTRL_LEAD_BIT  = 2;
  localparam int CTRL_ANGLE_BIT = 3;

  // Field positions in the status register.
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_FIRED_BIT = 4;
  localparam int STAT_PHASE_LSB = 16;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic angle_en;
    logic lead_en;
    logic limit_en;
    logic qc_mode;
  } fol_ctrl_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_LEAD  = 4'b0010,
    ST_ALIGN = 4'b0100,
    ST_FAULT = 4'b1000
  } fol_state_t;

endpackage

/* design/fol_timer.sv */
// Fault onset delay, phase alignment and fault time limiter with APB registers.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - With the limiter enabled the output leaves fault for normal once the limit time has run.
// - The limit accepts 1 to 65000 ms in millisecond steps and has its own enable bit.
// - The limiter works and its lamp lights only when quick-change mode is selected.
// - With the lead delay enabled the switch to fault waits the set delay after a start.
// - The lead delay accepts 10 to 6000 ms, has an enable, and its lamp lights while enabled in quick-change mode.
// - The onset angle 0.0 to 359.9 degrees is a lag against the internal reference phase.
// - Lead delay and angle alignment work, and their lamps light, only in quick-change mode.
// - A direct command pulses at the start and a delayed command pulses at the real switch.
// - With only the delay on the switch is at its expiry, with neither it is immediate.
// - With only the angle on the switch is at the first reference match after the start.
// - With both on the delay runs out first and the switch waits for the next angle match.
// - The angle wait adds between zero and one full reference period after the delay.
// - A start comes from the panel fault key or from the external start input.
// - Limit expiry acts as a recovery command alongside the external recovery input.
module fol_timer #(
  parameter int MS_CYCLES = fol_pkg::MS_CYCLES
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        FAULT_KEY,
  input  wire logic        START_IN,
  input  wire logic        RECOVER_IN,
  output logic             FAULT_STATE,
  output logic             QC_DIRECT,
  output logic             QC_DELAYED,
  output logic             LED_LIMIT,
  output logic             LED_LEAD,
  output logic             LED_ANGLE
);

  // ---------------------------------------------------------------------
  // Clamp helper
  // ---------------------------------------------------------------------
  // Out-of-range settings are pulled to the nearest legal value so the
  // timers never see a zero or oversized count.
  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------
  fol_pkg::fol_ctrl_t  ctrl_reg;
  logic [15:0]         limit_reg;
  logic [15:0]         lead_reg;
  logic [11:0]         angle_reg;
  logic [23:0]         step_reg;
  logic                fired_reg;
  logic [31:0]         prdata_reg;

  // ---------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------
  logic                wr_acc;
  logic                rd_setup;
  logic                hit_ctrl;
  logic                hit_limit;
  logic                hit_lead;
  logic                hit_angle;
  logic                hit_step;
  logic                hit_status;
  logic                mapped;
  logic [31:0]         status_word;
  logic [31:0]         rd_mux;

  // Zero-wait slave; unmapped addresses answer with an error and read zero.
  assign hit_ctrl    = (PADDR == fol_pkg::ADDR_CTRL);
  assign hit_limit   = (PADDR == fol_pkg::ADDR_LIMIT);
  assign hit_lead    = (PADDR == fol_pkg::ADDR_LEAD);
  assign hit_angle   = (PADDR == fol_pkg::ADDR_ANGLE);
  assign hit_step    = (PADDR == fol_pkg::ADDR_STEP);
  assign hit_status  = (PADDR == fol_pkg::ADDR_STATUS);
  assign mapped      = hit_ctrl | hit_limit | hit_lead | hit_angle | hit_step | hit_status;
  assign wr_acc      = PSEL & PENABLE & PWRITE;
  assign rd_setup    = PSEL & ~PENABLE & ~PWRITE;
  assign PREADY      = 1'b1;
  assign PSLVERR     = PSEL & PENABLE & ~mapped;

  // ---------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------------
  logic [2:0]          sync1_reg;
  logic [2:0]          sync2_reg;
  logic [2:0]          sync3_reg;
  logic [2:0]          rise;
  logic                start_cmd;
  logic                recover_cmd;

  // Two stages per pin; the third stage only serves edge detection.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
    end else begin
      sync1_reg <= {RECOVER_IN, START_IN, FAULT_KEY};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign rise      = sync2_reg & ~sync3_reg;
  assign start_cmd = rise[0] | rise[1];

  // ---------------------------------------------------------------------
  // Reference phase accumulator
  // ---------------------------------------------------------------------
  logic [23:0]         frac_reg;
  logic [11:0]         phase_reg;
  logic [24:0]         frac_sum;
  logic                phase_tick;
  logic [11:0]         phase_next;
  logic                angle_match;

  // Phase counts tenths of a degree; a step below one tenth per clock
  // guarantees the count moves by at most one, so no angle is skipped.
  assign frac_sum    = {1'b0, frac_reg} + {1'b0, step_reg};
  assign phase_tick  = frac_sum[24];
  assign phase_next  = (phase_reg == fol_pkg::PHASE_LAST) ? 12'h000 : phase_reg + 12'h001;
  assign angle_match = phase_tick & (phase_next == angle_reg);

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      frac_reg  <= 24'h000000;
      phase_reg <= 12'h000;
    end else begin
      frac_reg  <= frac_sum[23:0];
      if (phase_tick) begin
        phase_reg <= phase_next;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Millisecond timebase and sequence state
  // ---------------------------------------------------------------------
  fol_pkg::fol_state_t state_reg;
  fol_pkg::fol_state_t state_next;
  logic [15:0]         presc_reg;
  logic [15:0]         ms_reg;
  logic                ms_tick;
  logic [15:0]         ms_inc;
  logic                lead_on;
  logic                angle_on;
  logic                limit_on;
  logic                lead_done;
  logic                limit_done;
  logic                restart;
  logic                go_fault;
  logic                direct_next;

  assign ms_tick     = (presc_reg == 16'(MS_CYCLES - 1));
  assign ms_inc      = ms_reg + 16'h0001;
  assign lead_on     = ctrl_reg.qc_mode & ctrl_reg.lead_en;
  assign angle_on    = ctrl_reg.qc_mode & ctrl_reg.angle_en;
  assign limit_on    = ctrl_reg.qc_mode & ctrl_reg.limit_en;
  assign lead_done   = ms_tick & (ms_inc >= lead_reg);
  assign limit_done  = (state_reg == fol_pkg::ST_FAULT) & limit_on
                     & ms_tick & (ms_inc >= limit_reg);
  assign recover_cmd = rise[2] | limit_done;

  // Next state; recovery outranks a start landing in the same cycle.
  always_comb begin
    state_next  = state_reg;
    direct_next = 1'b0;
    if (recover_cmd) begin
      state_next = fol_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        fol_pkg::ST_IDLE: begin
          if (start_cmd) begin
            direct_next = 1'b1;
            if (lead_on) begin
              state_next = fol_pkg::ST_LEAD;
            end else if (angle_on) begin
              state_next = fol_pkg::ST_ALIGN;
            end else begin
              state_next = fol_pkg::ST_FAULT;
            end
          end
        end
        fol_pkg::ST_LEAD: begin
          // Starts here are ignored.
          if (lead_done) begin
            state_next = angle_on ? fol_pkg::ST_ALIGN : fol_pkg::ST_FAULT;
          end
        end
        fol_pkg::ST_ALIGN: begin
          // Wait is at most one reference period.
          if (angle_match) begin
            state_next = fol_pkg::ST_FAULT;
          end
        end
        fol_pkg::ST_FAULT: begin
          state_next = fol_pkg::ST_FAULT;
        end
        default: begin
          state_next = fol_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign restart  = (state_next != state_reg);
  assign go_fault = (state_next == fol_pkg::ST_FAULT) & (state_reg != fol_pkg::ST_FAULT);

  // The timebase restarts on every state change so each delay is exact.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_reg <= fol_pkg::ST_IDLE;
      presc_reg <= 16'h0000;
      ms_reg    <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (restart) begin
        presc_reg <= 16'h0000;
        ms_reg    <= 16'h0000;
      end else if (ms_tick) begin
        presc_reg <= 16'h0000;
        ms_reg    <= ms_inc;
      end else begin
        presc_reg <= presc_reg + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      FAULT_STATE <= 1'b0;
      QC_DIRECT   <= 1'b0;
      QC_DELAYED  <= 1'b0;
      LED_LIMIT   <= 1'b0;
      LED_LEAD    <= 1'b0;
      LED_ANGLE   <= 1'b0;
    end else begin
      FAULT_STATE <= (state_next == fol_pkg::ST_FAULT);
      QC_DIRECT   <= direct_next;
      QC_DELAYED  <= go_fault;
      LED_LIMIT   <= limit_on;
      LED_LEAD    <= lead_on;
      LED_ANGLE   <= angle_on;
    end
  end

  // ---------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------
  // Settings are clamped on write to the documented ranges.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl_reg  <= '0;
      limit_reg <= fol_pkg::RST_LIMIT;
      lead_reg  <= fol_pkg::RST_LEAD;
      angle_reg <= fol_pkg::RST_ANGLE;
      step_reg  <= fol_pkg::RST_STEP;
    end else if (wr_acc) begin
      if (hit_ctrl) begin
        ctrl_reg <= PWDATA[3:0];
      end
      if (hit_limit) begin
        limit_reg <= clamp16(PWDATA[15:0], fol_pkg::LIMIT_MIN_MS, fol_pkg::LIMIT_MAX_MS);
      end
      if (hit_lead) begin
        lead_reg <= clamp16(PWDATA[15:0], fol_pkg::LEAD_MIN_MS, fol_pkg::LEAD_MAX_MS);
      end
      if (hit_angle) begin
        angle_reg <= (PWDATA[11:0] > fol_pkg::ANGLE_MAX) ? fol_pkg::ANGLE_MAX : PWDATA[11:0];
      end
      if (hit_step) begin
        step_reg <= PWDATA[23:0];
      end
    end
  end

  // Sticky limiter flag; a new expiry outranks the software clear.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      fired_reg <= 1'b0;
    end else if (limit_done) begin
      fired_reg <= 1'b1;
    end else if (wr_acc & hit_status & PWDATA[fol_pkg::STAT_FIRED_BIT]) begin
      fired_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------
  assign status_word = {4'h0, phase_reg, 11'h000, fired_reg, state_reg};
  assign rd_mux      = hit_ctrl   ? {28'h0000000, ctrl_reg} :
                       hit_limit  ? {16'h0000, limit_reg} :
                       hit_lead   ? {16'h0000, lead_reg} :
                       hit_angle  ? {20'h00000, angle_reg} :
                       hit_step   ? {8'h00, step_reg} :
                       hit_status ? status_word : 32'h00000000;

  // Read data is captured in the setup cycle so it is ready at the access.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      prdata_reg <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_reg <= rd_mux;
    end
  end

  assign PRDATA = prdata_reg;

endmodule

`default_nettype wire

/* dv/fol_timer_monitor.sv */
// Port-level checker for the fault onset and limit timer.
`timescale 1ns/1ps
`default_nettype none

module fol_timer_monitor #(
  parameter int MS_CYCLES = 40000
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PSLVERR,
  input wire logic FAULT_KEY,
  input wire logic START_IN,
  input wire logic RECOVER_IN,
  input wire logic FAULT_STATE,
  input wire logic QC_DIRECT,
  input wire logic QC_DELAYED,
  input wire logic LED_LIMIT,
  input wire logic LED_LEAD,
  input wire logic LED_ANGLE
);
  // -------------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // A completed register write, the only legal cause of a lamp change.
  logic wr_acc;
  assign wr_acc = PSEL && PENABLE && PWRITE;

  a_direct_pulse: assert property (QC_DIRECT |=> !QC_DIRECT)
    else $error("direct command longer than one cycle");
  a_delayed_switch: assert property (QC_DELAYED |-> FAULT_STATE && !$past(FAULT_STATE))
    else $error("delayed command not at the switch to fault");
  a_rise_has_cmd: assert property ($rose(FAULT_STATE) |-> QC_DELAYED)
    else $error("fault entered without delayed command");
  a_no_retrigger: assert property (FAULT_STATE && $past(FAULT_STATE) |-> !QC_DIRECT)
    else $error("start accepted while in fault");
  a_start_source: assert property (QC_DIRECT |-> $past(FAULT_KEY, 3) || $past(START_IN, 3))
    else $error("direct command without a start pin");
  a_recover_acts: assert property ($rose(RECOVER_IN) |-> ##[1:6] !FAULT_STATE)
    else $error("recovery did not end fault");
  a_led_follows: assert property ($changed({LED_LIMIT, LED_LEAD, LED_ANGLE}) |->
    $past(wr_acc) || $past(wr_acc, 2) || $past(wr_acc, 3))
    else $error("lamp changed without a register write");
  a_err_access: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("error response outside access phase");

  c_delayed: cover property (QC_DIRECT && !QC_DELAYED);
  c_fall: cover property ($fell(FAULT_STATE));
  c_err: cover property (PSLVERR);
endmodule

`default_nettype wire

/* dv/fol_panel.sv */
// Model of the panel operator and start and recovery pins.
`timescale 1ns/1ps
`default_nettype none

module fol_panel (
  input  wire logic clk,
  output logic      fault_key,
  output logic      start_in,
  output logic      recover_in
);
  int hold = 0;

  initial begin
    fault_key = 1'b0;
    start_in = 1'b0;
    recover_in = 1'b0;
  end

  // Raises one pin for eight cycles; 0 key, 1 start input, 2 recovery.
  task automatic press(input int which);
    hold <= 8;
    if (which == 0) fault_key <= 1'b1;
    if (which == 1) start_in <= 1'b1;
    if (which == 2) recover_in <= 1'b1;
  endtask

  // Release on a rising edge like all other stimulus; presses share one hold count, and its end releases every pin.
  always @(posedge clk) begin
    if (hold == 1) begin
      fault_key <= 1'b0;
      start_in <= 1'b0;
      recover_in <= 1'b0;
    end
    if (hold > 0) hold <= hold - 1;
  end
endmodule

`default_nettype wire

/* dv/fol_timer_tb.sv */
// Self-checking testbench for the fault onset and limit timer.
`timescale 1ns/1ps
`default_nettype none

module fol_timer_tb;
  localparam int MSC = 10;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, fault_key, start_in, recover_in;
  wire         fault_state, qc_direct, qc_delayed, led_limit, led_lead, led_angle;
  logic [31:0] rd;
  logic        last_err;
  int          num_errors = 0;
  int          check_count = 0;
  int          n_direct = 0;
  int          lat, nd, rv[5];

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (qc_direct === 1'b1) n_direct++;

  fol_panel i_panel (.clk(clk_sys), .fault_key(fault_key), .start_in(start_in),
    .recover_in(recover_in));

  fol_timer #(.MS_CYCLES(MSC)) i_dut (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FAULT_KEY(fault_key), .START_IN(start_in),
    .RECOVER_IN(recover_in), .FAULT_STATE(fault_state), .QC_DIRECT(qc_direct),
    .QC_DELAYED(qc_delayed), .LED_LIMIT(led_limit), .LED_LEAD(led_lead), .LED_ANGLE(led_angle));

  // -------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts sampled cycles until the output reaches fault.
  task automatic wait_fault();
    lat = 0;
    while (fault_state !== 1'b1 && lat < 9000) begin
      @(negedge clk_sys);
      lat++;
    end
  endtask

  // Start through a pin, then measure from the direct command to the switch.
  task automatic launch(input int src);
    int n;
    n = 0;
    i_panel.press(src);
    do begin
      @(negedge clk_sys);
      n++;
    end while (qc_direct !== 1'b1 && n < 20);
    wait_fault();
  endtask

  task automatic hold_len();
    lat = 0;
    while (fault_state === 1'b1 && lat < 100) begin
      @(negedge clk_sys);
      lat++;
    end
  endtask

  task automatic recover();
    @(posedge clk_sys);
    i_panel.press(2);
    repeat (8) @(posedge clk_sys);
    check(fault_state, 1'b0);
  endtask

  task automatic finish_test();
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // -------------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------------
  initial begin
    rv = '{32'h0, 32'h3e8, 32'ha, 32'h0, 32'h126e9};
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values, then an unmapped place that must be refused.
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check(rd, rv[i]);
    end
    apb(1'b1, 8'h18, 32'hffff);
    check(last_err, 1'b1);
    apb(1'b0, 8'h18, 32'h0);
    check({last_err, rd}, {1'b1, 32'h0});
    // Out-of-range settings are clamped to the legal span.
    apb(1'b1, 8'h08, 32'h5);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'ha);
    apb(1'b1, 8'h04, 32'hfde9);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'hfde8);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, 8'h0c, 32'hfff);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd, 32'he0f);
    // Outside quick-change: dark lamps, immediate fault, no limiter.
    apb(1'b1, 8'h04, 32'h3);
    apb(1'b1, 8'h00, 32'he);
    repeat (3) @(posedge clk_sys);
    check({led_limit, led_lead, led_angle}, 3'b000);
    launch(0);
    check(lat, 0);
    hold_len();
    check(lat, 100);
    recover();
    // Quick-change with neither wait: immediate from the start input.
    apb(1'b1, 8'h00, 32'h1);
    launch(1);
    check(lat, 0);
    recover();
    // Lead delay only: exact delay, lamp lit, a second start ignored.
    apb(1'b1, 8'h00, 32'h5);
    repeat (3) @(posedge clk_sys);
    check({led_limit, led_lead, led_angle}, 3'b010);
    launch(0);
    check(lat, 10 * MSC);
    recover();
    nd = n_direct;
    @(posedge clk_sys);
    i_panel.press(0);
    repeat (40) @(posedge clk_sys);
    i_panel.press(1);
    wait_fault();
    check(n_direct - nd, 1);
    recover();
    // Limiter: fault lasts the set time, then the sticky flag is set and cleared.
    apb(1'b1, 8'h00, 32'h3);
    repeat (3) @(posedge clk_sys);
    check({led_limit, led_lead, led_angle}, 3'b100);
    launch(1);
    hold_len();
    check(lat, 3 * MSC);
    apb(1'b0, 8'h14, 32'h0);
    check(rd[4:0], 5'h11);
    apb(1'b1, 8'h14, 32'h10);
    apb(1'b0, 8'h14, 32'h0);
    check(rd[4], 1'b0);
    // Angle alignment alone, then behind the lead delay.
    apb(1'b1, 8'h10, 32'h800000);
    apb(1'b1, 8'h0c, 32'h384);
    apb(1'b1, 8'h00, 32'h9);
    repeat (3) @(posedge clk_sys);
    check({led_limit, led_lead, led_angle}, 3'b001);
    launch(0);
    check(lat <= 7202, 1'b1);
    apb(1'b0, 8'h14, 32'h0);
    check((rd[27:16] + 3600 - 12'h384) % 3600 < 12, 1'b1);
    recover();
    apb(1'b1, 8'h00, 32'hd);
    launch(1);
    check(lat >= 10 * MSC && lat <= 10 * MSC + 7202, 1'b1);
    recover();
    finish_test();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (60000) @(posedge clk_sys);
    num_errors++;
    finish_test();
  end
endmodule

bind fol_timer fol_timer_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (.CLK_SYS(CLK_SYS), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PSLVERR(PSLVERR), .FAULT_KEY(FAULT_KEY),
  .START_IN(START_IN), .RECOVER_IN(RECOVER_IN), .FAULT_STATE(FAULT_STATE),
  .QC_DIRECT(QC_DIRECT), .QC_DELAYED(QC_DELAYED), .LED_LIMIT(LED_LIMIT),
  .LED_LEAD(LED_LEAD), .LED_ANGLE(LED_ANGLE));

`default_nettype wire
